// ==== rtl/lsr_cfg.svh ====
/*
  Constants of the status readback bank: register indices, field positions, reset values.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef LSR_CFG_SVH
`define LSR_CFG_SVH
// status register indices
`define LSR_IDX_STATUS2 4'h2
`define LSR_IDX_STATUS3 4'h3
`define LSR_IDX_QUICK 4'h4
`define LSR_IDX_PAIR_FIRST 4'h5
`define LSR_IDX_PAIR_LAST 4'h8
`define LSR_IDX_RANGE 4'h9
`define LSR_IDX_OUTEN 4'ha
// common header field positions
`define LSR_POS_ADDR 12
`define LSR_POS_FAIL 11
`define LSR_POS_SVF 10
`define LSR_POS_DONT_CARE 9
`define LSR_POS_DSF 8
// device status 2 fields
`define LSR_POS_TSD 3
`define LSR_POS_TW 2
`define LSR_POS_OV 1
`define LSR_POS_UV 0
// channel pair word fields
`define LSR_POS_OUTPUT_LEVEL_READBACK 7
`define LSR_POS_PTSD 6
`define LSR_POS_TWH 5
`define LSR_POS_TWL 4
`define LSR_POS_OC_HI 3
`define LSR_POS_OC_LO 1
// reset values
`define LSR_RESET_WORD 16'h0000
`define LSR_RESET_BYTE 8'h00
`endif

// ==== rtl/lsr_pkg.sv ====
/*
  Types shared by the status readback bank.
  Assumes lsr_cfg.svh on the include path.
*/
package lsr_pkg;
  `include "lsr_cfg.svh"

  // raw per-channel fault inputs, one bit per channel
  typedef struct packed {
    logic [7:0] thermal_shutdown;
    logic [7:0] warning_high;
    logic [7:0] warning_low;
    logic [7:0] overcurrent;
    logic [7:0] open_load;
  } lsr_chan_type;

  // raw device-level fault inputs
  typedef struct packed {
    logic logic_supply_fail;
    logic serial_link_fail;
    logic limp_input;
    logic pwm_clock_fail;
    logic external_resistor_fail;
    logic watchdog_error;
  } lsr_dev_type;

  // read transaction state
  typedef enum logic [0:0] {LSR_IDLE, LSR_READING} lsr_read_type;
endpackage

// ==== rtl/lsr_sticky_flag.sv ====
/*
  One read-and-clear flag: sets on its event, clears on the end of a read.
  Assumes the clear is a one-cycle pulse; a set in the same cycle wins.
*/
`timescale 1ns/1ps
module lsr_sticky_flag #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // control
  input wire logic [WIDTH-1:0] set_event,
  input wire logic clear,
  // state
  output logic [WIDTH-1:0] flag
);
  logic [WIDTH-1:0] next_flag;

  // set beats clear so no event is lost
  always_comb begin
    next_flag = clear ? '0 : flag;
    next_flag = next_flag | set_event;
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      flag <= '0;
    end else begin
      flag <= next_flag;
    end
  end
endmodule // lsr_sticky_flag

// ==== rtl/lsr_word_mux.sv ====
/*
  Selects the status word for a register index and appends the common header.
  Assumes body words are already formed; unused indices read as zero body.
*/
`timescale 1ns/1ps
`include "lsr_cfg.svh"
module lsr_word_mux
  import lsr_pkg::*;
(
  // selection
  input wire logic [3:0] index,
  // common header bits
  input wire logic fail_mode_flag,
  input wire logic supply_fault_summary,
  input wire logic device_fault_summary,
  // bodies
  input wire logic [7:0] body_status2,
  input wire logic [7:0] body_status3,
  input wire logic [7:0] body_quick,
  input wire logic [31:0] body_pairs,
  input wire logic [7:0] body_range,
  input wire logic [7:0] body_outen,
  // result
  output logic [15:0] word
);
  logic [7:0] body;
  logic [1:0] pair_sel;

  assign pair_sel = 2'(index - `LSR_IDX_PAIR_FIRST);

  // body by index
  always_comb begin
    body = 8'h00;
    if (index == `LSR_IDX_STATUS2) body = body_status2;
    else if (index == `LSR_IDX_STATUS3) body = body_status3;
    else if (index == `LSR_IDX_QUICK) body = body_quick;
    else if (index >= `LSR_IDX_PAIR_FIRST && index <= `LSR_IDX_PAIR_LAST)
      body = body_pairs[pair_sel*8 +: 8];
    else if (index == `LSR_IDX_RANGE) body = body_range;
    else if (index == `LSR_IDX_OUTEN) body = body_outen;
  end

  // header: address, fail mode, summaries, bit 9 zero
  always_comb begin
    word = {index, fail_mode_flag, supply_fault_summary, 1'b0, device_fault_summary, body};
  end
endmodule // lsr_word_mux

// ==== rtl/lsr_status_bank.sv ====
/*
  Status and diagnostic readback bank of an eight-channel high-side switch driver.
  Builds the 16-bit status words read by the serial host, latches the read-and-clear
  flags, and gates the per-channel output enables on supply, thermal and overcurrent faults.
  Assumes the serial front end gives a register index, a read-active level while chip
  select is low, and a one-cycle pulse on the rising chip select edge that ends a read.
  All inputs are synchronous to CLOCK.
  Events seen while a read is open are replayed at its clearing edge, so the clear
  only removes what the frozen word could already show; the cost is one extra
  event vector of flip-flops.
*/
//
// Summary of operation
// - bit 11 of every word is 1 in fail mode, 0 in normal mode.
// - bit 10 ORs all main and per-pair supply over/undervoltage flags.
// - bit 8 ORs logic-supply, serial, limp, clock, resistor and watchdog faults.
// - status 2 bit 2 is set while any thermal warning flag is set.
// - status 2 bit 1 latches main supply overvoltage.
// - status 2 bit 0 latches main supply undervoltage.
// - status 3 bits 7,6 flag supply A faults, which turn channels 1,2 off.
// - status 3 bits 5,4 flag supply B faults, which turn channels 3,4 off.
// - status 3 bits 3,2 flag supply C faults, which turn channels 5,6 off.
// - status 3 bits 1,0 flag supply D faults, which turn channels 7,8 off.
// - per-pair supply flags latch and do not follow the live level.
// - quick status bits 7:0 OR each channel's thermal, overcurrent, open-load flags.
// - pair word bit 7 returns live level of the selected output channel.
// - pair word bit 6 latches thermal shutdown, which turns the pair off.
// - pair word bit 5 follows the high thermal warning live, no latch.
// - pair word bit 4 flags low thermal warning on either channel.
// - pair word bits 3,1 latch overcurrent, which turns that channel off.
// - mode word bits 7:0 echo range bits; 0 is 1.5A, 1 is 750mA.
// - words sit at indices 2 to 10, reset to zero, bits 15:12 hold index.
// - output-enable word bits 7:0 mirror the enables in force.
// - read-and-clear flags clear on the chip select edge ending the read.
// - the suppress bit blocks the automatic clear after a read.
// - a flag raised during a read is kept for the next read.
`timescale 1ns/1ps
`include "lsr_cfg.svh"
module lsr_status_bank
  import lsr_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // serial front end
  input wire logic [3:0] READ_INDEX,
  input wire logic READ_ACTIVE,
  input wire logic READ_END,
  output logic [15:0] READ_WORD,
  // initialization register fields
  input wire logic SUPPRESS_READ_CLEAR,
  input wire logic [2:0] OUTPUT_SELECT,
  // control register echoes
  input wire logic [CHANNELS-1:0] CURRENT_RANGE_SELECT,
  input wire logic [CHANNELS-1:0] REQUESTED_ENABLE,
  // mode
  input wire logic FAIL_MODE,
  // analogue fault detectors
  input wire logic MAIN_OVERVOLTAGE,
  input wire logic MAIN_UNDERVOLTAGE,
  input wire logic [3:0] PAIR_OVERVOLTAGE,
  input wire logic [3:0] PAIR_UNDERVOLTAGE,
  input wire lsr_chan_type CHANNEL_FAULTS,
  input wire lsr_dev_type DEVICE_FAULTS,
  input wire logic [CHANNELS-1:0] OUTPUT_LEVEL,
  // gated output enables
  output logic [CHANNELS-1:0] CHANNEL_OUTPUT_ENABLE
);
  logic clear_pulse;
  logic [1:0] main_flags;
  logic [3:0] pair_ov_flags;
  logic [3:0] pair_uv_flags;
  logic [CHANNELS-1:0] tsd_flags;
  logic [CHANNELS-1:0] oc_flags;
  logic [CHANNELS-1:0] twl_flags;
  logic [CHANNELS-1:0] ol_flags;
  logic [CHANNELS-1:0] pair_supply_fault;
  logic [CHANNELS-1:0] pair_tsd;
  logic [CHANNELS-1:0] next_enable;
  logic [CHANNELS-1:0] channel_fault_summary;
  logic [31:0] body_pairs;
  logic [7:0] body_status2;
  logic [7:0] body_status3;
  logic [7:0] body_range;
  logic [7:0] body_outen;
  logic [15:0] next_word;
  logic thermal_warning_summary;
  logic supply_fault_summary;
  logic device_fault_summary;
  logic output_level_readback;
  lsr_read_type read_state;
  lsr_read_type next_read_state;
  // latched event sources: live, seen during a read, and both together
  localparam int EVENTS = 10 + 4 * CHANNELS;
  logic [EVENTS-1:0] raw_event;
  logic [EVENTS-1:0] late_event;
  logic [EVENTS-1:0] next_late_event;
  logic [EVENTS-1:0] held_event;

  // read tracking: word is frozen at read start so a mid-read flag waits
  always_comb begin
    next_read_state = read_state;
    unique case (read_state)
      LSR_IDLE: if (READ_ACTIVE) next_read_state = LSR_READING;
      LSR_READING: if (READ_END) next_read_state = LSR_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      read_state <= LSR_IDLE;
    end else begin
      read_state <= next_read_state;
    end
  end

  // clear only on the edge that ends a read, unless suppressed
  assign clear_pulse = READ_END && (read_state == LSR_READING) && !SUPPRESS_READ_CLEAR;

  // every latched event source in one vector, main supply at the top
  always_comb begin
    raw_event = '0;
    raw_event[4*CHANNELS+9 -: 2] = {MAIN_OVERVOLTAGE, MAIN_UNDERVOLTAGE};
    raw_event[4*CHANNELS+7 -: 4] = PAIR_OVERVOLTAGE;
    raw_event[4*CHANNELS+3 -: 4] = PAIR_UNDERVOLTAGE;
    raw_event[4*CHANNELS-1 -: CHANNELS] = CHANNEL_FAULTS.thermal_shutdown;
    raw_event[3*CHANNELS-1 -: CHANNELS] = CHANNEL_FAULTS.overcurrent;
    raw_event[2*CHANNELS-1 -: CHANNELS] = CHANNEL_FAULTS.warning_low;
    raw_event[CHANNELS-1 -: CHANNELS] = CHANNEL_FAULTS.open_load;
  end

  // events from the freezing edge on are kept until the clearing edge,
  // otherwise a short fault during a read would vanish unreported
  always_comb begin
    next_late_event = '0;
    if (next_read_state == LSR_READING) begin
      next_late_event = late_event | raw_event;
    end
  end

  // emptied on the clearing edge itself, after it has been applied
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      late_event <= '0;
    end else begin
      late_event <= next_late_event;
    end
  end

  // set inputs of the latches: live events plus those seen during the read
  assign held_event = raw_event | late_event;

  // main supply flags latch
  lsr_sticky_flag #(.WIDTH(2)) u_main (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .set_event(held_event[4*CHANNELS+9 -: 2]),
    .clear(clear_pulse),
    .flag(main_flags)
  );

  // per-pair supply flags latch, ignoring the live level afterwards
  lsr_sticky_flag #(.WIDTH(4)) u_pair_ov (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .set_event(held_event[4*CHANNELS+7 -: 4]),
    .clear(clear_pulse),
    .flag(pair_ov_flags)
  );

  lsr_sticky_flag #(.WIDTH(4)) u_pair_uv (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .set_event(held_event[4*CHANNELS+3 -: 4]),
    .clear(clear_pulse),
    .flag(pair_uv_flags)
  );

  // thermal shutdown, overcurrent, low warning and open load latch per channel
  lsr_sticky_flag #(.WIDTH(CHANNELS)) u_tsd (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .set_event(held_event[4*CHANNELS-1 -: CHANNELS]),
    .clear(clear_pulse),
    .flag(tsd_flags)
  );

  lsr_sticky_flag #(.WIDTH(CHANNELS)) u_oc (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .set_event(held_event[3*CHANNELS-1 -: CHANNELS]),
    .clear(clear_pulse),
    .flag(oc_flags)
  );

  lsr_sticky_flag #(.WIDTH(CHANNELS)) u_twl (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .set_event(held_event[2*CHANNELS-1 -: CHANNELS]),
    .clear(clear_pulse),
    .flag(twl_flags)
  );

  lsr_sticky_flag #(.WIDTH(CHANNELS)) u_ol (
    .CLOCK(CLOCK),
    .RESET(RESET),
    .set_event(held_event[CHANNELS-1 -: CHANNELS]),
    .clear(clear_pulse),
    .flag(ol_flags)
  );

  // spread pair faults onto both channels of each pair
  always_comb begin
    for (int p = 0; p < CHANNELS / 2; p++) begin
      pair_supply_fault[2*p] = pair_ov_flags[3-p] | pair_uv_flags[3-p];
      pair_supply_fault[2*p+1] = pair_ov_flags[3-p] | pair_uv_flags[3-p];
      pair_tsd[2*p] = tsd_flags[2*p] | tsd_flags[2*p+1];
      pair_tsd[2*p+1] = tsd_flags[2*p] | tsd_flags[2*p+1];
    end
  end

  // enables in force: requested minus every latched cut-off
  always_comb begin
    next_enable = REQUESTED_ENABLE & ~pair_supply_fault & ~pair_tsd & ~oc_flags;
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      CHANNEL_OUTPUT_ENABLE <= `LSR_RESET_BYTE;
    end else begin
      CHANNEL_OUTPUT_ENABLE <= next_enable;
    end
  end

  // summaries: supply and device for every word header, plus status 2 warning, quick status and pair level readback
  assign supply_fault_summary = |main_flags | |pair_ov_flags | |pair_uv_flags;
  assign device_fault_summary = |DEVICE_FAULTS;
  assign thermal_warning_summary = |twl_flags | |CHANNEL_FAULTS.warning_high;
  assign channel_fault_summary = tsd_flags | CHANNEL_FAULTS.warning_high | twl_flags
                               | oc_flags | ol_flags;
  assign output_level_readback = OUTPUT_LEVEL[OUTPUT_SELECT];

  // device status 2 and 3 bodies
  always_comb begin
    body_status2 = 8'h00;
    body_status2[`LSR_POS_TSD] = |tsd_flags;
    body_status2[`LSR_POS_TW] = thermal_warning_summary;
    body_status2[`LSR_POS_OV] = main_flags[1];
    body_status2[`LSR_POS_UV] = main_flags[0];
    body_status3 = {pair_ov_flags[3], pair_uv_flags[3], pair_ov_flags[2], pair_uv_flags[2],
                    pair_ov_flags[1], pair_uv_flags[1], pair_ov_flags[0],
                    pair_uv_flags[0]};
  end

  // channel pair bodies; bits 2 and 0 left zero
  always_comb begin
    body_pairs = 32'h0000_0000;
    for (int p = 0; p < 4; p++) begin
      body_pairs[p*8 + `LSR_POS_OUTPUT_LEVEL_READBACK] = output_level_readback;
      body_pairs[p*8 + `LSR_POS_PTSD] = pair_tsd[2*p];
      body_pairs[p*8 + `LSR_POS_TWH] = CHANNEL_FAULTS.warning_high[2*p]
                                     | CHANNEL_FAULTS.warning_high[2*p+1];
      body_pairs[p*8 + `LSR_POS_TWL] = twl_flags[2*p] | twl_flags[2*p+1];
      body_pairs[p*8 + `LSR_POS_OC_HI] = oc_flags[2*p+1];
      body_pairs[p*8 + `LSR_POS_OC_LO] = oc_flags[2*p];
    end
  end

  // echo words
  assign body_range = CURRENT_RANGE_SELECT;
  assign body_outen = CHANNEL_OUTPUT_ENABLE;

  // assembled word for the requested index
  lsr_word_mux u_mux (
    .index(READ_INDEX),
    .fail_mode_flag(FAIL_MODE),
    .supply_fault_summary(supply_fault_summary),
    .device_fault_summary(device_fault_summary),
    .body_status2(body_status2),
    .body_status3(body_status3),
    .body_quick(channel_fault_summary),
    .body_pairs(body_pairs),
    .body_range(body_range),
    .body_outen(body_outen),
    .word(next_word)
  );

  // word captured while idle, held through the read
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      READ_WORD <= `LSR_RESET_WORD;
    end else if (read_state == LSR_IDLE) begin
      READ_WORD <= next_word;
    end
  end
endmodule // lsr_status_bank

// ==== testbench/lsr_status_bank_properties.sv ====
/*
  Port assertions for the status readback bank.
  Assumes the bind below and a single clock with synchronous reset.
*/
`timescale 1ns/1ps
module lsr_bank_properties
  import lsr_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // watched ports
  input wire logic [3:0] READ_INDEX,
  input wire logic READ_ACTIVE,
  input wire logic READ_END,
  input wire logic [15:0] READ_WORD,
  input wire logic [CHANNELS-1:0] CURRENT_RANGE_SELECT,
  input wire logic [CHANNELS-1:0] REQUESTED_ENABLE,
  input wire logic FAIL_MODE,
  input wire logic MAIN_OVERVOLTAGE,
  input wire logic [3:0] PAIR_OVERVOLTAGE,
  input wire lsr_chan_type CHANNEL_FAULTS,
  input wire lsr_dev_type DEVICE_FAULTS,
  input wire logic [CHANNELS-1:0] CHANNEL_OUTPUT_ENABLE
);
  logic in_read;
  logic next_in_read;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  // shadow of the read state, so idle and frozen cycles can be told apart
  always_comb begin
    next_in_read = READ_END ? 1'b0 : (READ_ACTIVE ? 1'b1 : in_read);
  end
  always_ff @(posedge CLOCK) begin
    in_read <= RESET ? 1'b0 : next_in_read;
  end
  a_addr_field: assert property (!in_read |=> READ_WORD[15:12] == $past(READ_INDEX))
    else $error("address field differs from index");
  a_fail_bit: assert property (!in_read |=> READ_WORD[11] == $past(FAIL_MODE))
    else $error("fail mode bit wrong");
  a_dev_summary: assert property (!in_read |=> READ_WORD[8] == (|$past(DEVICE_FAULTS)))
    else $error("device fault summary wrong");
  a_bit9_zero: assert property (READ_WORD[9] == 1'b0)
    else $error("bit 9 not zero");
  a_read_frozen: assert property (in_read |=> $stable(READ_WORD))
    else $error("word moved during a read");
  a_range_echo: assert property (!in_read && READ_INDEX == 4'h9 |=>
    READ_WORD[7:0] == $past(CURRENT_RANGE_SELECT)) else $error("range echo wrong");
  a_pair_gate: assert property (PAIR_OVERVOLTAGE[3] [*2] |=>
    CHANNEL_OUTPUT_ENABLE[1:0] == 2'b00) else $error("supply fault left pair on");
  a_oc_gate: assert property (CHANNEL_FAULTS.overcurrent[0] [*2] |=>
    CHANNEL_OUTPUT_ENABLE[0] == 1'b0) else $error("overcurrent left channel on");
  a_enable_mask: assert property ((CHANNEL_OUTPUT_ENABLE & ~$past(REQUESTED_ENABLE)) == '0)
    else $error("enable without request");
  a_supply_sum: assert property (MAIN_OVERVOLTAGE ##1 !in_read |=> READ_WORD[10])
    else $error("supply summary missing");
endmodule // lsr_bank_properties

bind lsr_status_bank lsr_bank_properties #(.CHANNELS(CHANNELS)) u_props (
  .CLOCK(CLOCK), .RESET(RESET), .READ_INDEX(READ_INDEX), .READ_ACTIVE(READ_ACTIVE),
  .READ_END(READ_END), .READ_WORD(READ_WORD), .CURRENT_RANGE_SELECT(CURRENT_RANGE_SELECT),
  .REQUESTED_ENABLE(REQUESTED_ENABLE), .FAIL_MODE(FAIL_MODE),
  .MAIN_OVERVOLTAGE(MAIN_OVERVOLTAGE), .PAIR_OVERVOLTAGE(PAIR_OVERVOLTAGE),
  .CHANNEL_FAULTS(CHANNEL_FAULTS), .DEVICE_FAULTS(DEVICE_FAULTS),
  .CHANNEL_OUTPUT_ENABLE(CHANNEL_OUTPUT_ENABLE));

// ==== testbench/lsr_serial_host.sv ====
/*
  Serial host model: opens a read, lets the word settle, ends it with a chip select edge.
  Assumes callers enter its tasks just after a rising clock edge.
*/
`timescale 1ns/1ps
module lsr_serial_host (
  // clock and returned word
  input wire logic clock,
  input wire logic [15:0] read_word,
  // front end strobes
  output logic [3:0] read_index,
  output logic read_active,
  output logic read_end
);
  // idle with chip select high
  initial begin
    read_index = 4'h0;
    read_active = 1'b0;
    read_end = 1'b0;
  end
  // three idle edges so the word tracks the new index before it freezes
  task automatic start_read(input logic [3:0] idx);
    read_index = idx;
    repeat (3) @(posedge clock);
    #1;
    read_active = 1'b1;
    @(posedge clock);
    #1;
  endtask
  // take the frozen word, then one end pulse as chip select rises
  task automatic end_read(output logic [15:0] word);
    @(posedge clock);
    #1;
    word = read_word;
    read_active = 1'b0;
    read_end = 1'b1;
    @(posedge clock);
    #1;
    read_end = 1'b0;
  endtask
endmodule // lsr_serial_host

// ==== testbench/tb_lsr_status_bank.sv ====
/*
  Self-checking bench for the status readback bank.
  Assumes the host model and the bound checker; all stimulus 1 ns after the edge.
*/
`timescale 1ns/1ps
module tb_lsr_status_bank;
  import lsr_pkg::*;
  logic clock, reset, suppress, fail_mode, main_ov, main_uv, read_active, read_end;
  logic [3:0] read_index, pair_ov, pair_uv;
  logic [2:0] out_sel;
  logic [7:0] range_sel, req_en, out_level, chan_en;
  logic [15:0] read_word, w;
  lsr_chan_type chan_f;
  lsr_dev_type dev_f;
  int bad_count, n_tests;

  lsr_serial_host u_host (.clock(clock), .read_word(read_word), .read_index(read_index),
    .read_active(read_active), .read_end(read_end));
  lsr_status_bank #(.CHANNELS(8)) u_dut (.CLOCK(clock), .RESET(reset),
    .READ_INDEX(read_index), .READ_ACTIVE(read_active), .READ_END(read_end),
    .READ_WORD(read_word), .SUPPRESS_READ_CLEAR(suppress), .OUTPUT_SELECT(out_sel),
    .CURRENT_RANGE_SELECT(range_sel), .REQUESTED_ENABLE(req_en), .FAIL_MODE(fail_mode),
    .MAIN_OVERVOLTAGE(main_ov), .MAIN_UNDERVOLTAGE(main_uv), .PAIR_OVERVOLTAGE(pair_ov),
    .PAIR_UNDERVOLTAGE(pair_uv), .CHANNEL_FAULTS(chan_f), .DEVICE_FAULTS(dev_f),
    .OUTPUT_LEVEL(out_level), .CHANNEL_OUTPUT_ENABLE(chan_en));

  // 25 ns period
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one full read; hdr is fail mode, supply summary, device summary
  task automatic rd(input logic [3:0] idx, input logic [7:0] body, input logic [2:0] hdr);
    u_host.start_read(idx);
    u_host.end_read(w);
    check("status word", {idx, hdr[2], hdr[1], 1'b0, hdr[0], body}, w);
  endtask
  // wipes every latched flag before the next scenario
  task automatic clear_all();
    for (int i = 2; i < 10; i++) begin
      u_host.start_read(4'(i));
      u_host.end_read(w);
    end
  endtask

  task automatic test_idle_words();
    for (int i = 2; i < 11; i++)
      rd(4'(i), 8'h00, 3'b000);
  endtask
  task automatic test_header();
    fail_mode = 1'b1;
    for (int i = 0; i < 6; i++) begin
      dev_f = 6'(1 << i);
      rd(4'h9, 8'h00, 3'b101);
    end
    dev_f = '0;
    rd(4'h4, 8'h00, 3'b100);
    fail_mode = 1'b0;
  endtask
  task automatic test_main_supply();
    main_ov = 1'b1;
    tick(1);
    main_ov = 1'b0;
    rd(4'h2, 8'h02, 3'b010);
    rd(4'h2, 8'h00, 3'b000);
    suppress = 1'b1;
    main_uv = 1'b1;
    tick(1);
    main_uv = 1'b0;
    rd(4'h2, 8'h01, 3'b010);
    rd(4'h2, 8'h01, 3'b010);
    suppress = 1'b0;
    rd(4'h2, 8'h01, 3'b010);
    rd(4'h2, 8'h00, 3'b000);
  endtask
  // supplies A..D gate channel pairs 1+2 .. 7+8
  task automatic test_pair_supplies();
    req_en = 8'hff;
    for (int k = 0; k < 4; k++) begin
      pair_ov[3-k] = 1'b1;
      pair_uv[3-k] = 1'b1;
      tick(2);
      pair_ov = 4'h0;
      pair_uv = 4'h0;
      tick(1);
      check("enables", 16'(8'hff & ~(8'h03 << 2*k)), 16'(chan_en));
      rd(4'h3, 8'hc0 >> 2*k, 3'b010);
      tick(3);
      check("enables", 16'h00ff, 16'(chan_en));
    end
  endtask
  task automatic test_channel_faults();
    chan_f.thermal_shutdown = 8'h04;
    tick(1);
    chan_f = '0;
    tick(2);
    check("enables", 16'h00f3, 16'(chan_en));
    rd(4'h6, 8'h40, 3'b000);
    clear_all();
    chan_f.warning_high = 8'h80;
    rd(4'h8, 8'h20, 3'b000);
    rd(4'h2, 8'h04, 3'b000);
    rd(4'h4, 8'h80, 3'b000);
    chan_f = '0;
    rd(4'h8, 8'h00, 3'b000);
    chan_f.warning_low = 8'h01;
    rd(4'h5, 8'h10, 3'b000);
    chan_f = '0;
    clear_all();
    chan_f.overcurrent = 8'h01;
    chan_f.open_load = 8'h02;
    tick(2);
    check("enables", 16'h00fe, 16'(chan_en));
    rd(4'h5, 8'h02, 3'b000);
    rd(4'h4, 8'h03, 3'b000);
    chan_f = '0;
    clear_all();
  endtask
  task automatic test_level_readback();
    for (int k = 0; k < 8; k++) begin
      out_sel = 3'(k);
      out_level = 8'(1 << k);
      rd(4'h5 + 4'(k / 2), 8'h80, 3'b000);
      out_level = ~out_level;
      rd(4'h5, 8'h00, 3'b000);
    end
  endtask
  task automatic test_echo_and_mid_read();
    range_sel = 8'h3c;
    rd(4'h9, 8'h3c, 3'b000);
    req_en = 8'h5a;
    rd(4'ha, 8'h5a, 3'b000);
    u_host.start_read(4'h7);
    chan_f.overcurrent = 8'h10;
    tick(1);
    chan_f = '0;
    u_host.end_read(w);
    check("frozen word", 16'h7000, w);
    rd(4'h7, 8'h02, 3'b000);
  endtask

  // a hang counts as a mismatch
  initial begin
    #400us;
    bad_count++;
    stop_test();
  end
  initial begin
    {reset, suppress, fail_mode, main_ov, main_uv} = 5'h10;
    {pair_ov, pair_uv, out_sel} = '0;
    {range_sel, req_en, out_level} = '0;
    chan_f = '0;
    dev_f = '0;
    bad_count = 0;
    n_tests = 0;
    tick(5);
    check("reset word", 16'h0000, read_word);
    reset = 1'b0;
    test_idle_words();
    test_header();
    test_main_supply();
    test_pair_supplies();
    test_channel_faults();
    test_level_readback();
    test_echo_and_mid_read();
    stop_test();
  end
endmodule // tb_lsr_status_bank
